// ---- design/regulator_channel_pkg.sv ----
// Package with register offsets, field positions and reset values of the regulator channel bank.
package regulator_channel_pkg;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 8;
    localparam int NUM_CHANNELS = 5;
    localparam logic [7:0] BUCK_CH1_CONTROL = 8'h22;
    localparam logic [7:0] BUCK_CH2_PRIMARY_VOLTAGE = 8'h30;
    localparam logic [7:0] BUCK_CH2_SECONDARY_VOLTAGE = 8'h31;
    localparam logic [7:0] BUCK_CH2_CONTROL = 8'h32;
    localparam logic [7:0] BUCK_CH3_PRIMARY_VOLTAGE = 8'h40;
    localparam logic [7:0] BUCK_CH3_SECONDARY_VOLTAGE = 8'h41;
    localparam logic [7:0] BUCK_CH3_CONTROL = 8'h42;
    localparam logic [7:0] LINEAR_CH4_VOLTAGE = 8'h50;
    localparam logic [7:0] LINEAR_CH4_CONTROL = 8'h51;
    localparam logic [7:0] LINEAR_CH5_VOLTAGE = 8'h54;
    localparam logic [7:0] LINEAR_CH5_CONTROL = 8'h55;
    localparam logic [7:0] IRQ_STATUS = 8'hF0;
    localparam logic [7:0] IRQ_MASK = 8'hF1;
    localparam int ENABLE_BIT = 7;
    localparam int OPTION_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int DELAY_HI = 4;
    localparam int DELAY_LO = 2;
    localparam int FAULT_MASK_BIT = 1;
    localparam int POWER_GOOD_BIT = 0;
    localparam int CODE_WIDTH = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
endpackage

// ---- design/regulator_channel_control_regs.sv ----
// Control and status register bank for the regulator channels.
`timescale 1ns/10ps
// Operation
// [RULE1] Step-down channel uses primary code while voltage-select pin is low.
// [RULE2] Step-down channel uses secondary code while voltage-select pin is high.
// [RULE3] Control bit 7 turns the channel on when 1, off when 0.
// [RULE4] Second converter phase bit 1 switches 180 degrees from oscillator.
// [RULE5] Converter mode bit 1 forces fixed-frequency PWM, 0 allows power saving.
// [RULE6] Control bits 4 to 2 hold a turn-on delay code for the sequencer.
// [RULE7] Channel faults reach the interrupt only while its mask bit is 1.
// [RULE8] Control bit 0 reads 1 while output is above power-good threshold.
// [RULE9] Third converter policy bit 0 enables it while push-button is asserted.
// [RULE10] Linear discharge bit 1 discharges output while regulator is off.
// [RULE11] Linear low-quiescent bit 1 selects low-power operating mode.
// [RULE12] Third converter holds policy bit in bit 6, other fields unchanged.
// [RULE13] Undervoltage or power loss returns every register bit to default.
// [RULE14] Voltage-code bits 7 and 6 read zero and ignore writes.
// [RULE15] Unmasked enabled channel losing power-good raises the interrupt.
module regulator_channel_control_regs #(
    parameter int NUM_CHANNELS = regulator_channel_pkg::NUM_CHANNELS,
    parameter int CODE_WIDTH = regulator_channel_pkg::CODE_WIDTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    input wire logic voltageSelectPin,
    input wire logic pushbuttonInput_n,
    input wire logic [4:0] powerGoodIn,
    output logic [4:0] channelEnable,
    output logic [5:0] buckCh2ActiveCode,
    output logic [5:0] buckCh3ActiveCode,
    output logic [5:0] linearCh4Code,
    output logic [5:0] linearCh5Code,
    output logic buckCh2AntiPhase,
    output logic [2:0] forcedPwm,
    output logic [14:0] turnOnDelay,
    output logic [1:0] linearDischarge,
    output logic [1:0] linearLowQuiescent,
    output logic interruptOut
);
    // Control registers per channel: index 0 = ch1 ... 4 = ch5.
    logic [7:0] control [NUM_CHANNELS];
    logic [5:0] primaryCode [2];
    logic [5:0] secondaryCode [2];
    logic [5:0] linearCode [2];
    logic [4:0] irqStatus;
    logic [4:0] irqMask;
    logic [4:0] pgSync1;
    logic [4:0] pgSync2;
    logic [4:0] pgLast;
    logic selSync1;
    logic selSync2;
    logic pbSync1;
    logic pbSync2;
    logic [4:0] pgFall;
    logic [4:0] writeOneClear;
    logic [7:0] next_readData;
    logic [4:0] controlWriteSel;
    logic [5:0] codeWriteSel;
    logic statusWriteSel;
    logic maskWriteSel;
    logic [4:0] enableBit;
    logic [4:0] optionBit;
    logic [4:0] modeBit;
    logic [4:0] faultMaskBit;
    logic [14:0] delayField;
    logic [4:0] enableRequest;
    logic buttonForce;
    logic irqPending;

    // The register map and port widths are fixed, so other sizes cannot be served.
    if (NUM_CHANNELS != regulator_channel_pkg::NUM_CHANNELS) begin : gen_bad_channels
        $error("channel count must match the fixed register map");
    end
    if (CODE_WIDTH != regulator_channel_pkg::CODE_WIDTH) begin : gen_bad_code_width
        $error("voltage code width must match the fixed register map");
    end
    // The control field positions must leave three bits for the delay code.
    if (regulator_channel_pkg::DELAY_HI - regulator_channel_pkg::DELAY_LO != 2) begin : gen_dly
        $error("turn-on delay field must be three bits wide");
    end
    if (regulator_channel_pkg::DATA_WIDTH != 8) begin : gen_bad_data
        $error("register data path must be eight bits wide");
    end
    if (regulator_channel_pkg::ADDR_WIDTH != 8) begin : gen_bad_addr
        $error("register address must be eight bits wide");
    end
    // The mode bit sits directly above the delay field and power-good at the bottom.
    if (regulator_channel_pkg::MODE_BIT != regulator_channel_pkg::DELAY_HI + 1) begin : gen_mode
        $error("mode bit must sit above the delay field");
    end
    if (regulator_channel_pkg::POWER_GOOD_BIT != 0) begin : gen_pg
        $error("power-good status must be bit zero");
    end

    // Power-good pins pass two flip-flops; a third stage feeds the falling-edge detector.
    always_ff @(posedge clock) begin
        if (rst) begin
            pgSync1 <= 5'h00;
            pgSync2 <= 5'h00;
            pgLast <= 5'h00;
        end else begin
            pgSync1 <= powerGoodIn;
            pgSync2 <= pgSync1;
            pgLast <= pgSync2;
        end
    end

    // Voltage-select pin synchroniser; it resets to the primary code.
    always_ff @(posedge clock) begin
        if (rst) begin
            selSync1 <= 1'b0;
            selSync2 <= 1'b0;
        end else begin
            selSync1 <= voltageSelectPin;
            selSync2 <= selSync1;
        end
    end

    // Push-button synchroniser; it resets to released so no false press follows reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            pbSync1 <= 1'b1;
            pbSync2 <= 1'b1;
        end else begin
            pbSync1 <= pushbuttonInput_n;
            pbSync2 <= pbSync1;
        end
    end

    // Write decode of the channel registers: one select each, none when unmapped.
    always_comb begin
        controlWriteSel = 5'h00;
        codeWriteSel = 6'h00;
        if (!writeStrobe) begin
            codeWriteSel = 6'h00;
        end else if (address == regulator_channel_pkg::BUCK_CH1_CONTROL) begin
            controlWriteSel[0] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH2_CONTROL) begin
            controlWriteSel[1] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH3_CONTROL) begin
            controlWriteSel[2] = 1'b1; // [RULE12]
        end else if (address == regulator_channel_pkg::LINEAR_CH4_CONTROL) begin
            controlWriteSel[3] = 1'b1;
        end else if (address == regulator_channel_pkg::LINEAR_CH5_CONTROL) begin
            controlWriteSel[4] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH2_PRIMARY_VOLTAGE) begin
            codeWriteSel[0] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH2_SECONDARY_VOLTAGE) begin
            codeWriteSel[1] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH3_PRIMARY_VOLTAGE) begin
            codeWriteSel[2] = 1'b1;
        end else if (address == regulator_channel_pkg::BUCK_CH3_SECONDARY_VOLTAGE) begin
            codeWriteSel[3] = 1'b1;
        end else if (address == regulator_channel_pkg::LINEAR_CH4_VOLTAGE) begin
            codeWriteSel[4] = 1'b1;
        end else if (address == regulator_channel_pkg::LINEAR_CH5_VOLTAGE) begin
            codeWriteSel[5] = 1'b1;
        end
    end

    // Write decode of the interrupt registers.
    always_comb begin
        statusWriteSel = 1'b0;
        maskWriteSel = 1'b0;
        if (writeStrobe && address == regulator_channel_pkg::IRQ_STATUS) begin
            statusWriteSel = 1'b1;
        end else if (writeStrobe && address == regulator_channel_pkg::IRQ_MASK) begin
            maskWriteSel = 1'b1;
        end
    end

    // Control registers; bit 0 is stored but unused, power-good reads live.
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                control[i] <= regulator_channel_pkg::CONTROL_RESET; // [RULE13]
            end
        end else begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (controlWriteSel[i]) begin
                    control[i] <= writeData;
                end
            end
        end
    end

    // Voltage-code registers keep only the six low bits, so the top two read zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                primaryCode[i] <= regulator_channel_pkg::CODE_RESET; // [RULE13]
                secondaryCode[i] <= regulator_channel_pkg::CODE_RESET;
                linearCode[i] <= regulator_channel_pkg::CODE_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (codeWriteSel[2*i]) begin
                    primaryCode[i] <= writeData[5:0]; // [RULE14]
                end
                if (codeWriteSel[2*i+1]) begin
                    secondaryCode[i] <= writeData[5:0]; // [RULE14]
                end
                if (codeWriteSel[4+i]) begin
                    linearCode[i] <= writeData[5:0]; // [RULE14]
                end
            end
        end
    end

    // Writing a one to a status bit clears it.
    assign writeOneClear = statusWriteSel ? writeData[4:0] : 5'h00;

    // Per-channel control fields, picked out at the package's bit positions.
    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++) begin : gen_fields
            assign enableBit[g] = control[g][regulator_channel_pkg::ENABLE_BIT];
            assign optionBit[g] = control[g][regulator_channel_pkg::OPTION_BIT];
            assign modeBit[g] = control[g][regulator_channel_pkg::MODE_BIT];
            assign faultMaskBit[g] = control[g][regulator_channel_pkg::FAULT_MASK_BIT];
            assign delayField[3*g +: 3] =
                control[g][regulator_channel_pkg::DELAY_HI:regulator_channel_pkg::DELAY_LO];
            // Fault event: synchronised power-good falls while enabled and unmasked.
            assign pgFall[g] = pgLast[g] & ~pgSync2[g] & enableBit[g] & faultMaskBit[g]; // [RULE7] [RULE15]
        end
    endgenerate

    // The push-button holds the third converter on while its policy bit is 0.
    assign buttonForce = ~optionBit[2] & ~pbSync2; // [RULE9]
    assign enableRequest = enableBit | {2'b00, buttonForce, 2'b00}; // [RULE3] [RULE9]
    assign irqPending = |(irqStatus & irqMask);

    // Sticky status; a new event wins over a clear in the same cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            irqStatus <= 5'h00;
        end else begin
            irqStatus <= (irqStatus & ~writeOneClear) | pgFall; // [RULE15]
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clock) begin
        if (rst) begin
            irqMask <= regulator_channel_pkg::IRQ_MASK_RESET;
        end else if (maskWriteSel) begin
            irqMask <= writeData[4:0];
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        next_readData = 8'h00;
        if (address == regulator_channel_pkg::BUCK_CH1_CONTROL) begin
            next_readData = {control[0][7:1], pgSync2[0]}; // [RULE8]
        end else if (address == regulator_channel_pkg::BUCK_CH2_CONTROL) begin
            next_readData = {control[1][7:1], pgSync2[1]}; // [RULE8]
        end else if (address == regulator_channel_pkg::BUCK_CH3_CONTROL) begin
            next_readData = {control[2][7:1], pgSync2[2]}; // [RULE8]
        end else if (address == regulator_channel_pkg::LINEAR_CH4_CONTROL) begin
            next_readData = {control[3][7:1], pgSync2[3]}; // [RULE8]
        end else if (address == regulator_channel_pkg::LINEAR_CH5_CONTROL) begin
            next_readData = {control[4][7:1], pgSync2[4]}; // [RULE8]
        end else if (address == regulator_channel_pkg::BUCK_CH2_PRIMARY_VOLTAGE) begin
            next_readData = {2'b00, primaryCode[0]}; // [RULE14]
        end else if (address == regulator_channel_pkg::BUCK_CH2_SECONDARY_VOLTAGE) begin
            next_readData = {2'b00, secondaryCode[0]};
        end else if (address == regulator_channel_pkg::BUCK_CH3_PRIMARY_VOLTAGE) begin
            next_readData = {2'b00, primaryCode[1]};
        end else if (address == regulator_channel_pkg::BUCK_CH3_SECONDARY_VOLTAGE) begin
            next_readData = {2'b00, secondaryCode[1]};
        end else if (address == regulator_channel_pkg::LINEAR_CH4_VOLTAGE) begin
            next_readData = {2'b00, linearCode[0]};
        end else if (address == regulator_channel_pkg::LINEAR_CH5_VOLTAGE) begin
            next_readData = {2'b00, linearCode[1]};
        end else if (address == regulator_channel_pkg::IRQ_STATUS) begin
            next_readData = {3'b000, irqStatus};
        end else if (address == regulator_channel_pkg::IRQ_MASK) begin
            next_readData = {3'b000, irqMask};
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clock) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (readStrobe) begin
            readData <= next_readData;
        end else begin
            readData <= 8'h00;
        end
    end

    // Channel enables and turn-on delay codes for the sequencer.
    always_ff @(posedge clock) begin
        if (rst) begin
            channelEnable <= 5'h00;
            turnOnDelay <= 15'h0000;
        end else begin
            channelEnable <= enableRequest; // [RULE3] [RULE9]
            turnOnDelay <= delayField; // [RULE6]
        end
    end

    // Active converter codes; the synchronised select pin picks the code.
    always_ff @(posedge clock) begin
        if (rst) begin
            buckCh2ActiveCode <= 6'h00;
            buckCh3ActiveCode <= 6'h00;
        end else begin
            buckCh2ActiveCode <= selSync2 ? secondaryCode[0] : primaryCode[0]; // [RULE1] [RULE2]
            buckCh3ActiveCode <= selSync2 ? secondaryCode[1] : primaryCode[1]; // [RULE1] [RULE2]
        end
    end

    // Linear regulator codes pass straight through.
    always_ff @(posedge clock) begin
        if (rst) begin
            linearCh4Code <= 6'h00;
            linearCh5Code <= 6'h00;
        end else begin
            linearCh4Code <= linearCode[0];
            linearCh5Code <= linearCode[1];
        end
    end

    // Converter options: phase of the second converter and forced PWM.
    always_ff @(posedge clock) begin
        if (rst) begin
            buckCh2AntiPhase <= 1'b0;
            forcedPwm <= 3'b000;
        end else begin
            buckCh2AntiPhase <= optionBit[1]; // [RULE4]
            forcedPwm <= modeBit[2:0]; // [RULE5]
        end
    end

    // Linear options: discharge only while the regulator is off, and low-quiescent mode.
    always_ff @(posedge clock) begin
        if (rst) begin
            linearDischarge <= 2'b00;
            linearLowQuiescent <= 2'b00;
        end else begin
            linearDischarge <= optionBit[4:3] & ~enableBit[4:3]; // [RULE10]
            linearLowQuiescent <= modeBit[4:3]; // [RULE11]
        end
    end

    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge clock) begin
        if (rst) begin
            interruptOut <= 1'b0;
        end else begin
            interruptOut <= irqPending; // [RULE15]
        end
    end
endmodule

// ---- tb/regulator_channel_control_regs_assertions.sv ----
// Checker with concurrent assertions for the regulator channel register bank.
`timescale 1ns/10ps
module regulator_channel_control_regs_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] readData,
    input wire logic voltageSelectPin,
    input wire logic pushbuttonInput_n,
    input wire logic [4:0] channelEnable,
    input wire logic [5:0] buckCh2ActiveCode,
    input wire logic buckCh2AntiPhase,
    input wire logic [2:0] forcedPwm,
    input wire logic [14:0] turnOnDelay,
    input wire logic [1:0] linearDischarge,
    input wire logic [1:0] linearLowQuiescent,
    input wire logic interruptOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [7:0] w1;
    logic [7:0] w2;
    // Keeps the write data of two cycles back for the control write checks.
    always_ff @(posedge clock) begin
        w1 <= writeData;
        w2 <= w1;
    end
    sequence calm; !writeStrobe[*4]; endsequence
    sequence ctlWrite(a); writeStrobe && address == a ##1 !(writeStrobe && address == a); endsequence
    ch2_control_a: assert property (ctlWrite(8'h32) |=>
        channelEnable[1] == w2[7] &&
        buckCh2AntiPhase == w2[6] && forcedPwm[1] == w2[5] && turnOnDelay[5:3] == w2[4:2])
        else $error("second converter outputs differ from its control write");
    ch5_control_a: assert property (ctlWrite(8'h55) |=> channelEnable[4] == w2[7] &&
        linearDischarge[1] == (w2[6] && !w2[7]) && linearLowQuiescent[1] == w2[5])
        else $error("fifth channel outputs differ from its control write");
    reset_zero_a: assert property (disable iff (1'b0) rst |=> channelEnable == 5'h00 &&
        interruptOut == 1'b0 && readData == 8'h00 && forcedPwm == 3'h0)
        else $error("outputs not cleared by reset");
    read_idle_a: assert property (!readStrobe |=> readData == 8'h00)
        else $error("read data present without a read");
    code_reserved_a: assert property (readStrobe && address inside {8'h30, 8'h31, 8'h40,
        8'h41, 8'h50, 8'h54} |=> readData[7:6] == 2'b00) else $error("reserved code bits set");
    primary_sel_a: assert property ((!voltageSelectPin)[*6] ##0 calm ##0 readStrobe &&
        address == 8'h30 |=> buckCh2ActiveCode == readData[5:0]) else $error("primary code unused");
    secondary_sel_a: assert property (voltageSelectPin[*6] ##0 calm ##0 readStrobe &&
        address == 8'h31 |=> buckCh2ActiveCode == readData[5:0]) else $error("secondary code unused");
    button_ch3_a: assert property ((!pushbuttonInput_n)[*6] ##0 calm ##0 readStrobe &&
        address == 8'h42 |=> readData[6] || channelEnable[2]) else $error("button did not enable");
endmodule
bind regulator_channel_control_regs regulator_channel_control_regs_checker chk (.*);

// ---- tb/tb_regulator_channel_control_regs.sv ----
// Self-checking testbench for the regulator channel register bank.
`timescale 1ns/10ps
module tb_regulator_channel_control_regs;
    logic clock = 0, rst = 1, writeStrobe = 0, readStrobe = 0, seen = 0, anti, irq;
    logic voltageSelectPin = 0, pushbuttonInput_n = 1;
    logic [7:0] address = 8'h00, writeData = 8'h00, readData, msk;
    logic [4:0] powerGoodIn = 5'h00, channelEnable, ev;
    logic [5:0] code2, code3, code4, code5;
    logic [2:0] forcedPwm;
    logic [14:0] turnOnDelay;
    logic [1:0] dis, lowq;
    logic [7:0] expQ[$];
    logic [7:0] vals[11];
    logic [7:0] addrs[13] = '{8'h22, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51,
        8'h54, 8'h55, 8'hF0, 8'hF1};
    int n_fail = 0, checks_done = 0;
    regulator_channel_control_regs dut (.clock(clock), .rst(rst), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .voltageSelectPin(voltageSelectPin),
        .pushbuttonInput_n(pushbuttonInput_n), .powerGoodIn(powerGoodIn),
        .channelEnable(channelEnable), .buckCh2ActiveCode(code2), .buckCh3ActiveCode(code3),
        .linearCh4Code(code4), .linearCh5Code(code5), .buckCh2AntiPhase(anti),
        .forcedPwm(forcedPwm), .turnOnDelay(turnOnDelay), .linearDischarge(dis),
        .linearLowQuiescent(lowq), .interruptOut(irq));
    // Clock of 8 ns period.
    initial begin
        forever #4 clock = ~clock;
    end
    task automatic chk(input logic [14:0] got, input logic [14:0] e);
        checks_done++;
        if (got !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        readStrobe <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Compares read data with the oldest expectation in the cycle after each read.
    always @(posedge clock) begin
        if (seen) chk(readData, expQ.pop_front());
        seen <= readStrobe;
    end
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        close_out();
    end
    // Main sequence of scenarios.
    initial begin
        msk = 8'($urandom(67782));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        wr(8'h23, 8'hFF);
        rd(8'h23, 8'h00);
        for (int k = 0; k < 4; k++) begin
            voltageSelectPin <= k[0];
            for (int i = 0; i < 11; i++) begin
                vals[i] = 8'($urandom);
                wr(addrs[i], vals[i]);
            end
            for (int i = 0; i < 11; i++) begin
                msk = (addrs[i] inside {8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h54}) ? 8'h3F : 8'hFE;
                rd(addrs[i], vals[i] & msk);
            end
            chk(code2, k[0] ? vals[2][5:0] : vals[1][5:0]);
            chk(code3, k[0] ? vals[5][5:0] : vals[4][5:0]);
            chk({code5, code4}, {vals[9][5:0], vals[7][5:0]});
            chk(channelEnable,
                {vals[10][7], vals[8][7], vals[6][7], vals[3][7], vals[0][7]});
            chk(turnOnDelay,
                {vals[10][4:2], vals[8][4:2], vals[6][4:2], vals[3][4:2], vals[0][4:2]});
            chk({anti, forcedPwm}, {vals[3][6], vals[6][5], vals[3][5], vals[0][5]});
            chk(dis, {vals[10][6] & ~vals[10][7], vals[8][6] & ~vals[8][7]});
            chk(lowq, {vals[10][5], vals[8][5]});
        end
        wr(8'h42, 8'h00);
        pushbuttonInput_n <= 1'b0;
        // Long enough for the button to settle before the read the checker watches.
        repeat (8) @(posedge clock);
        rd(8'h42, 8'h00);
        chk(channelEnable[2], 1'b1);
        wr(8'h42, 8'h40);
        rd(8'h42, 8'h40);
        chk(channelEnable[2], 1'b0);
        pushbuttonInput_n <= 1'b1;
        powerGoodIn <= 5'h1F;
        wr(8'hF1, 8'h00);
        wr(8'h32, 8'h82);
        wr(8'h51, 8'h80);
        rd(8'h32, 8'h83);
        powerGoodIn <= 5'h00;
        ev = {vals[10][7] & vals[10][1], 3'b001, vals[0][7] & vals[0][1]};
        repeat (6) @(posedge clock);
        chk(irq, 1'b0);
        rd(8'hF0, {3'h0, ev});
        wr(8'hF1, 8'h02);
        repeat (2) @(posedge clock);
        chk(irq, 1'b1);
        wr(8'hF0, 8'h02);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        rd(8'hF0, {3'h0, ev & 5'h1D});
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'h32, 8'h00);
        chk({irq, channelEnable}, 6'h00);
        repeat (3) @(posedge clock);
        close_out();
    end
endmodule
